// ---- rtl/gpio_pin_cell.sv ----
// Generic port slice of WIDTH bits: latch, direction and unregistered pass-through pin levels
`timescale 1ns/1ps
module gpio_pin_cell #(
    parameter int         WIDTH     = 8,
    parameter logic [7:0] DIR_INIT  = 8'hFF
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              porReset,
    input  wire logic              latchWrite,
    input  wire logic              dirWrite,
    input  wire logic [WIDTH-1:0]  writeData,
    input  wire logic [WIDTH-1:0]  pinIn,
    output logic      [WIDTH-1:0]  latchOut,
    output logic      [WIDTH-1:0]  dirOut,
    output logic      [WIDTH-1:0]  pinLevel
);
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] dir_q;

    // Latch keeps its value on all resets except power-up kinds
    always_ff @(posedge ref_clk) begin
        if (porReset) begin
            latch_q <= gpio_ports_pkg::LATCH_POR_VALUE[WIDTH-1:0];
        end else if (latchWrite) begin
            latch_q <= writeData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dir_q <= DIR_INIT[WIDTH-1:0];
        end else if (dirWrite) begin
            dir_q <= writeData;
        end
    end

    assign latchOut = latch_q;
    assign dirOut   = dir_q;
    assign pinLevel = pinIn;
endmodule

// ---- rtl/gpio_ports_bus_mux.sv ----
// Top of the three-port GPIO block with system bus control muxing
// What this block does
// - A direction bit of one turns the pin into an input with its driver off.
// - A direction bit of zero makes the pin drive its output latch value; analog port pins drive only while selected digital.
// - Reads return pin levels while writes only change the output latch.
// - The control port has four bits and its upper bits read as zero.
// - In processor or extended modes the low three control pins carry latch, read and write strobes.
// - Read and write strobes are active low and address latch is active high.
// - In the two microcontroller modes those three pins are plain I/O.
// - The fourth control pin is always I/O and its level feeds capture four.
// - The analog port bits map to converter channels four to eleven in order.
// - After reset the analog port is analog and reads zero until software selects digital.
// - Directions reset to ones; latches load LATCH_POR_VALUE (zero) on power-up and are kept on other resets.
// - The analog port decodes only in bank five and the other two only in bank one.
// - In bus modes the high byte port carries address/data bits fifteen to eight.
`timescale 1ns/1ps
module gpio_ports_bus_mux #(
    parameter int W = gpio_ports_pkg::DATA_W
) (
    input  wire logic                                 ref_clk,
    input  wire logic                                 rst_n,
    input  wire logic                                 porReset,
    input  wire gpio_ports_pkg::opMode_type           opMode,
    input  wire logic [gpio_ports_pkg::BANK_W-1:0]    bank_select,
    input  wire logic [gpio_ports_pkg::ADDR_W-1:0]    regAddr,
    input  wire logic                                 regWrite,
    input  wire logic                                 regRead,
    input  wire logic [W-1:0]                         regWdata,
    output logic      [W-1:0]                         regRdata,
    output logic                                      regHit,
    input  wire logic [W-1:0]                         analogDigitalSel,
    output logic      [W-1:0]                         analogChanEnable,
    input  wire logic [W-1:0]                         analogPinIn,
    output logic      [W-1:0]                         analogPinOut,
    output logic      [W-1:0]                         analogPinOe,
    input  wire logic [W-1:0]                         highPinIn,
    output logic      [W-1:0]                         highPinOut,
    output logic      [W-1:0]                         highPinOe,
    input  wire logic                                 busAddrPhase,
    input  wire logic                                 busReadCycle,
    input  wire logic                                 busWriteCycle,
    input  wire logic [W-1:0]                         busHighOut,
    input  wire logic                                 busHighDrive,
    output logic      [W-1:0]                         busHighIn,
    input  wire logic [gpio_ports_pkg::CTRL_W-1:0]    ctrlPinIn,
    output logic      [gpio_ports_pkg::CTRL_W-1:0]    ctrlPinOut,
    output logic      [gpio_ports_pkg::CTRL_W-1:0]    ctrlPinOe,
    output logic                                      capture_four_input
);
    localparam int CW = gpio_ports_pkg::CTRL_W;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hitAt(input logic [7:0] a, input logic [7:0] ofs,
                                   input logic bankOk);
        return (a == ofs) && bankOk;
    endfunction

    // Upper control bits are not implemented and read back as zero
    function automatic logic [W-1:0] ctrlWide(input logic [CW-1:0] v);
        return {{(W-CW){1'b0}}, v};
    endfunction

    logic bankAna;
    logic bankDig;
    logic anaDirSel;
    logic anaValSel;
    logic highDirSel;
    logic highValSel;
    logic ctrlDirSel;
    logic ctrlValSel;
    logic busMode;

    // Same offsets in other banks belong to other blocks, so the bank is part of every decode
    assign bankAna    = (bank_select == gpio_ports_pkg::BANK_ANALOG);
    assign bankDig    = (bank_select == gpio_ports_pkg::BANK_DIGITAL);
    assign anaDirSel  = hitAt(regAddr, gpio_ports_pkg::OFS_ANA_DIR, bankAna);
    assign anaValSel  = hitAt(regAddr, gpio_ports_pkg::OFS_ANA_VAL, bankAna);
    assign highDirSel = hitAt(regAddr, gpio_ports_pkg::OFS_HIGH_DIR, bankDig);
    assign highValSel = hitAt(regAddr, gpio_ports_pkg::OFS_HIGH_VAL, bankDig);
    assign ctrlDirSel = hitAt(regAddr, gpio_ports_pkg::OFS_CTRL_DIR, bankDig);
    assign ctrlValSel = hitAt(regAddr, gpio_ports_pkg::OFS_CTRL_VAL, bankDig);
    assign busMode    = (opMode == gpio_ports_pkg::MODE_MICROPROC) ||
                        (opMode == gpio_ports_pkg::MODE_EXT_MICRO);

    // ----------------------------------------
    // Port slices
    // ----------------------------------------
    logic [W-1:0]  anaLatch;
    logic [W-1:0]  anaDir;
    logic [W-1:0]  anaLevel;
    logic [W-1:0]  highLatch;
    logic [W-1:0]  highDir;
    logic [W-1:0]  highLevel;
    logic [CW-1:0] ctrlLatch;
    logic [CW-1:0] ctrlDir;
    logic [CW-1:0] ctrlLevel;

    gpio_pin_cell #(.WIDTH(W), .DIR_INIT(gpio_ports_pkg::DIR_RESET)) anaCell (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .porReset   (porReset),
        .latchWrite (regWrite && anaValSel),
        .dirWrite   (regWrite && anaDirSel),
        .writeData  (regWdata),
        .pinIn      (analogPinIn),
        .latchOut   (anaLatch),
        .dirOut     (anaDir),
        .pinLevel   (anaLevel)
    );

    gpio_pin_cell #(.WIDTH(W), .DIR_INIT(gpio_ports_pkg::DIR_RESET)) highCell (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .porReset   (porReset),
        .latchWrite (regWrite && highValSel),
        .dirWrite   (regWrite && highDirSel),
        .writeData  (regWdata),
        .pinIn      (highPinIn),
        .latchOut   (highLatch),
        .dirOut     (highDir),
        .pinLevel   (highLevel)
    );

    // Control slice is four bits wide; upper write bits are dropped
    gpio_pin_cell #(.WIDTH(CW), .DIR_INIT({4'h0, gpio_ports_pkg::CTRL_DIR_RESET})) ctrlCell (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .porReset   (porReset),
        .latchWrite (regWrite && ctrlValSel),
        .dirWrite   (regWrite && ctrlDirSel),
        .writeData  (regWdata[CW-1:0]),
        .pinIn      (ctrlPinIn),
        .latchOut   (ctrlLatch),
        .dirOut     (ctrlDir),
        .pinLevel   (ctrlLevel)
    );

    // ----------------------------------------
    // Analog port
    // ----------------------------------------
    // Converter config decides digital use; reset value of that input is analog
    logic [W-1:0] anaDigital;
    assign anaDigital       = rst_n ? analogDigitalSel : '0;
    assign analogChanEnable = ~anaDigital;
    assign analogPinOe      = anaDigital & ~anaDir;
    assign analogPinOut     = anaLatch;

    // ----------------------------------------
    // High byte port
    // ----------------------------------------
    // Latch keeps its value while the bus owns the pins, ready for the return to I/O
    assign highPinOe  = busMode ? {W{busHighDrive}} : ~highDir;
    assign highPinOut = busMode ? busHighOut : highLatch;
    assign busHighIn  = highLevel;

    // ----------------------------------------
    // System bus strobes
    // ----------------------------------------
    // Only the low three pins turn into strobes; the capture pin stays I/O
    logic [CW-1:0] busCtrlOut;
    logic [CW-1:0] busCtrlMask;

    always_comb begin
        busCtrlOut                           = '0;
        busCtrlMask                          = '0;
        busCtrlOut[gpio_ports_pkg::BIT_ALE]  = busAddrPhase;
        busCtrlOut[gpio_ports_pkg::BIT_RD]   = ~busReadCycle;
        busCtrlOut[gpio_ports_pkg::BIT_WR]   = ~busWriteCycle;
        busCtrlMask[gpio_ports_pkg::BIT_ALE] = busMode;
        busCtrlMask[gpio_ports_pkg::BIT_RD]  = busMode;
        busCtrlMask[gpio_ports_pkg::BIT_WR]  = busMode;
    end

    // ----------------------------------------
    // Control port
    // ----------------------------------------
    always_comb begin
        ctrlPinOut = ctrlLatch;
        ctrlPinOe  = ~ctrlDir;
        for (int i = 0; i < CW; i++) begin
            if (busCtrlMask[i]) begin
                ctrlPinOut[i] = busCtrlOut[i];
                ctrlPinOe[i]  = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Capture input
    // ----------------------------------------
    assign capture_four_input = ctrlLevel[gpio_ports_pkg::BIT_CAP];

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Reads see the pins, so a read-modify-write copies input levels into the latch
    always_comb begin
        regRdata = '0;
        regHit   = 1'b0;
        if (regRead) begin
            regHit = 1'b1;
            if (anaDirSel) begin
                regRdata = anaDir;
            end else if (anaValSel) begin
                regRdata = anaLevel & anaDigital;
            end else if (highDirSel) begin
                regRdata = highDir;
            end else if (highValSel) begin
                regRdata = highLevel;
            end else if (ctrlDirSel) begin
                regRdata = ctrlWide(ctrlDir);
            end else if (ctrlValSel) begin
                regRdata = ctrlWide(ctrlLevel);
            end else begin
                regHit = 1'b0;
            end
        end
    end

endmodule

// ---- rtl/gpio_ports_pkg.sv ----
// Package: register offsets, banks, reset values and mode codes for the port block
package gpio_ports_pkg;
    localparam int          DATA_W           = 8;
    localparam int          CTRL_W           = 4;
    localparam int          BANK_W           = 4;
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  OFS_ANA_DIR      = 8'h10;
    localparam logic [7:0]  OFS_ANA_VAL      = 8'h11;
    localparam logic [7:0]  OFS_HIGH_DIR     = 8'h12;
    localparam logic [7:0]  OFS_HIGH_VAL     = 8'h13;
    localparam logic [7:0]  OFS_CTRL_DIR     = 8'h14;
    localparam logic [7:0]  OFS_CTRL_VAL     = 8'h15;
    localparam logic [3:0]  BANK_DIGITAL     = 4'h1;
    localparam logic [3:0]  BANK_ANALOG      = 4'h5;
    localparam logic [7:0]  DIR_RESET        = 8'hFF;
    localparam logic [3:0]  CTRL_DIR_RESET   = 4'hF;
    localparam logic [7:0]  ANA_READ_RESET   = 8'h00;
    localparam logic [7:0]  LATCH_POR_VALUE  = 8'h00;
    localparam int          BIT_ALE          = 0;
    localparam int          BIT_RD           = 1;
    localparam int          BIT_WR           = 2;
    localparam int          BIT_CAP          = 3;
    localparam int          FIRST_ANA_CHAN   = 4;
    // Operating mode from configuration bits
    typedef enum logic [1:0] {
        MODE_MICROPROC   = 2'h0,
        MODE_EXT_MICRO   = 2'h1,
        MODE_MICRO       = 2'h2,
        MODE_SAFE_MICRO  = 2'h3
    } opMode_type;
endpackage

// ---- tb/ext_bus_memory.sv ----
// Partner: small memory on the multiplexed system bus
`timescale 1ns/1ps
module ext_bus_memory (
    input  wire logic [2:0] ctrlLines,
    input  wire logic       ref_clk,
    input  wire logic [7:0] busLines,
    output logic      [7:0] driveData,
    output logic            driveEn
);
    logic [7:0] mem [16];
    logic [3:0] addr_q;
    always @(posedge ref_clk) begin
        if (ctrlLines[0]) begin
            addr_q <= busLines[3:0];
        end
        if (!ctrlLines[2] && !ctrlLines[0]) begin
            mem[addr_q] <= busLines;
        end
    end
    // Released otherwise, so the bench shows its own fixed highExt level instead
    assign driveEn = !ctrlLines[1] && !ctrlLines[0];
    assign driveData = mem[addr_q];
endmodule

// ---- tb/gpio_ports_checker_assertions.sv ----
// Checker: port-level timing and value relations of the three-port GPIO block
`timescale 1ns/1ps
module gpio_ports_checker (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire gpio_ports_pkg::opMode_type opMode,
    input wire logic [3:0]                 bank_select,
    input wire logic [7:0]                 regAddr,
    input wire logic                       regWrite,
    input wire logic                       regRead,
    input wire logic [7:0]                 regWdata,
    input wire logic [7:0]                 regRdata,
    input wire logic                       regHit,
    input wire logic [7:0]                 analogDigitalSel,
    input wire logic [7:0]                 analogChanEnable,
    input wire logic [7:0]                 analogPinOe,
    input wire logic [7:0]                 highPinOut,
    input wire logic [7:0]                 highPinOe,
    input wire logic                       busAddrPhase,
    input wire logic                       busReadCycle,
    input wire logic                       busWriteCycle,
    input wire logic [7:0]                 busHighOut,
    input wire logic                       busHighDrive,
    input wire logic [3:0]                 ctrlPinIn,
    input wire logic [3:0]                 ctrlPinOut,
    input wire logic [3:0]                 ctrlPinOe,
    input wire logic                       capture_four_input
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    miss_reads_zero_a: assert property (!regHit |-> regRdata == 8'h00) else $error("data without hit");
    chan_map_a: assert property (analogChanEnable == ~analogDigitalSel) else $error("channel map");
    analog_oe_a: assert property ((analogPinOe & ~analogDigitalSel) == 8'h00) else $error("analog pin driven");
    capture_pin_a: assert property (capture_four_input == ctrlPinIn[3]) else $error("capture level");
    bus_strobes_a: assert property (!opMode[1] |-> ctrlPinOe[2:0] == 3'h7 &&
        ctrlPinOut[2:0] == {~busWriteCycle, ~busReadCycle, busAddrPhase}) else $error("bus strobes");
    high_bus_a: assert property (!opMode[1] |-> highPinOut == busHighOut &&
        highPinOe == {8{busHighDrive}}) else $error("high byte bus");
    ctrl_read_a: assert property (regRead && bank_select == 4'h1 && regAddr == 8'h15
        |-> regHit && regRdata == {4'h0, ctrlPinIn}) else $error("control read");
    latch_write_a: assert property (regWrite && bank_select == 4'h1 && regAddr == 8'h13 && opMode[1]
        ##1 opMode[1] |-> highPinOut == $past(regWdata)) else $error("latch write");
    cover property (!opMode[1] && busWriteCycle);
    cover property (regWrite && regAddr == 8'h13);
    cover property (regRead && !regHit);
endmodule
bind gpio_ports_bus_mux gpio_ports_checker chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .opMode(opMode), .bank_select(bank_select), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
    .analogDigitalSel(analogDigitalSel), .analogChanEnable(analogChanEnable), .analogPinOe(analogPinOe),
    .highPinOut(highPinOut), .highPinOe(highPinOe), .busAddrPhase(busAddrPhase), .busReadCycle(busReadCycle),
    .busWriteCycle(busWriteCycle), .busHighOut(busHighOut), .busHighDrive(busHighDrive), .ctrlPinIn(ctrlPinIn),
    .ctrlPinOut(ctrlPinOut), .ctrlPinOe(ctrlPinOe), .capture_four_input(capture_four_input));

// ---- tb/test_gpio_ports_bus_mux.sv ----
// Testbench: registers, pins and system bus of the GPIO port block
`timescale 1ns/1ps
module test_gpio_ports_bus_mux;
    gpio_ports_pkg::opMode_type opMode = gpio_ports_pkg::MODE_MICRO;
    logic       ref_clk = 1'b0, rst_n = 1'b0, porReset = 1'b0, regWrite = 1'b0, regRead = 1'b0, regHit;
    logic       busAddrPhase = 1'b0, busReadCycle = 1'b0, busWriteCycle = 1'b0, busHighDrive = 1'b0;
    logic       capture_four_input, memEn;
    logic [3:0] bank_select = 4'h1, ctrlPinIn, ctrlPinOut, ctrlPinOe, ctrlExt = 4'h6;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, analogDigitalSel = 8'h00, analogChanEnable;
    logic [7:0] analogPinIn, analogPinOut, analogPinOe, analogExt = 8'h5A, highPinIn, highPinOut, highPinOe;
    logic [7:0] highExt = 8'h3C, busHighOut = 8'h00, busHighIn, memData;
    int         failCount = 0, checked = 0;
    always #2 ref_clk = ~ref_clk;
    assign highPinIn = (highPinOe & highPinOut) | (~highPinOe & (memEn ? memData : highExt));
    assign ctrlPinIn = (ctrlPinOe & ctrlPinOut) | (~ctrlPinOe & ctrlExt);
    assign analogPinIn = (analogPinOe & analogPinOut) | (~analogPinOe & analogExt);
    gpio_ports_bus_mux dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .porReset(porReset), .opMode(opMode), .bank_select(bank_select),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .regHit(regHit), .analogDigitalSel(analogDigitalSel), .analogChanEnable(analogChanEnable),
        .analogPinIn(analogPinIn), .analogPinOut(analogPinOut), .analogPinOe(analogPinOe),
        .highPinIn(highPinIn), .highPinOut(highPinOut), .highPinOe(highPinOe), .busAddrPhase(busAddrPhase),
        .busReadCycle(busReadCycle), .busWriteCycle(busWriteCycle), .busHighOut(busHighOut),
        .busHighDrive(busHighDrive), .busHighIn(busHighIn), .ctrlPinIn(ctrlPinIn), .ctrlPinOut(ctrlPinOut),
        .ctrlPinOe(ctrlPinOe), .capture_four_input(capture_four_input));
    ext_bus_memory partner (.ref_clk(ref_clk), .ctrlLines(ctrlPinIn[2:0]), .busLines(highPinIn),
        .driveData(memData), .driveEn(memEn));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic acc(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
        step();
        {bank_select, regAddr, regWdata, regWrite, regRead} = {b, a, d, w, r};
        #2;
    endtask
    task automatic wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
        acc(b, a, d, 1'b1, 1'b0);
        acc(b, 8'h00, 8'h00, 1'b0, 1'b0);
    endtask
    task automatic rd(input logic [3:0] b, input logic [7:0] a, input logic [7:0] exp);
        acc(b, a, 8'h00, 1'b0, 1'b1);
        check(regRdata, exp);
    endtask
    task automatic bus(input logic [3:0] c, input logic [7:0] d);
        step();
        {busAddrPhase, busReadCycle, busWriteCycle, busHighDrive, busHighOut} = {c, d};
        #2;
    endtask
    task automatic t_reset;
        rd(4'h5, 8'h10, 8'hFF);
        rd(4'h1, 8'h12, 8'hFF);
        rd(4'h1, 8'h14, 8'h0F);
        rd(4'h5, 8'h11, 8'h00);
    endtask
    task automatic t_gpio;
        wr(4'h1, 8'h13, 8'hA5);
        wr(4'h1, 8'h12, 8'h0F);
        check(highPinOe, 8'hF0);
        check(highPinOut & highPinOe, 8'hA0);
        rd(4'h1, 8'h13, 8'hAC);
        step();
        rst_n = 1'b0;
        step();
        rst_n = 1'b1;
        check(highPinOe, 8'h00);
        check(highPinOut, 8'hA5);
    endtask
    task automatic t_ctrl;
        wr(4'h1, 8'h15, 8'hF9);
        wr(4'h1, 8'h14, 8'hF0);
        check({4'h0, ctrlPinOe}, 8'h0F);
        rd(4'h1, 8'h15, 8'h09);
        rd(4'h1, 8'h14, 8'h00);
        check({7'h00, capture_four_input}, 8'h01);
        wr(4'h1, 8'h14, 8'hFF);
        rd(4'h1, 8'h15, 8'h06);
        check({7'h00, capture_four_input}, 8'h00);
    endtask
    task automatic t_bank;
        wr(4'h5, 8'h13, 8'h00);
        check(highPinOut, 8'hA5);
        rd(4'h5, 8'h13, 8'h00);
        check({7'h00, regHit}, 8'h00);
        rd(4'h1, 8'h10, 8'h00);
    endtask
    task automatic t_analog;
        step();
        analogDigitalSel = 8'h0F;
        rd(4'h5, 8'h11, 8'h0A);
        check(analogChanEnable, 8'hF0);
        wr(4'h5, 8'h11, 8'h33);
        check(analogPinOut, 8'h33);
        wr(4'h5, 8'h10, 8'h00);
        check(analogPinOe, 8'h0F);
        rd(4'h5, 8'h11, 8'h03);
    endtask
    task automatic t_bus;
        for (int m = 0; m < 2; m++) begin
            step();
            opMode = gpio_ports_pkg::opMode_type'(m);
            bus(4'h9, 8'h03);
            check({5'h00, ctrlPinOut[2:0]}, 8'h07);
            bus(4'h3, 8'hC4 + m[7:0]);
            check({5'h00, ctrlPinOut[2:0]}, 8'h02);
            bus(4'h9, 8'h03);
            bus(4'h4, 8'h00);
            check({5'h00, ctrlPinOut[2:0]}, 8'h04);
            check(busHighIn, 8'hC4 + m[7:0]);
            bus(4'h0, 8'h00);
        end
        step();
        opMode = gpio_ports_pkg::MODE_SAFE_MICRO;
        step();
        check({4'h0, ctrlPinOe}, 8'h00);
    endtask
    task automatic t_power;
        step();
        {porReset, rst_n} = 2'b10;
        step();
        {porReset, rst_n} = 2'b01;
        check(highPinOut, gpio_ports_pkg::LATCH_POR_VALUE);
        check({4'h0, ctrlPinOut}, gpio_ports_pkg::LATCH_POR_VALUE);
        check(highPinOe, 8'h00);
    endtask
    task automatic finish_test;
        if (failCount == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_gpio();
        t_ctrl();
        t_bank();
        t_analog();
        t_bus();
        t_power();
        finish_test();
    end
endmodule
